// ==== aisl_pkg.sv ====
package aisl_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_INPUT_LEVEL = 8'h00;
    localparam logic [7:0] OFS_COUNTER_SEL = 8'h04;
    localparam logic [7:0] OFS_ERC_CFG = 8'h08;
    localparam logic [7:0] OFS_PIN_FUNC = 8'h0C;
    localparam logic [7:0] OFS_OUT_PORT = 8'h10;
    localparam logic [7:0] OFS_OUT_BIT = 8'h14;
    localparam logic [7:0] OFS_EXT_STATUS = 8'h18;

    // Synchronised input positions
    localparam int IN_DR_PLUS = 0;
    localparam int IN_DR_MINUS = 1;
    localparam int IN_POS_START = 2;
    localparam int IN_IN_POS = 3;
    localparam int IN_CNT_RESET = 4;
    localparam int IN_CNT_CAPTURE = 5;
    localparam int IN_ORIGIN = 6;
    localparam int NUM_IN = 7;
    localparam int NUM_PINS = 8;

    // Counter select register fields
    localparam int SEL_CLEAR_LSB = 0;
    localparam int SEL_CAPTURE_LSB = 4;
    localparam int SEL_FEED_LSB = 8;
    localparam int SEL_PULSE_LSB = 10;

    // Servo clear register fields
    localparam int ERC_WIDTH_LSB = 0;
    localparam int ERC_ACT_HIGH_BIT = 16;
    localparam int ERC_LEVEL_MODE_BIT = 17;
    localparam int ERC_LEVEL_ON_BIT = 18;

    // Pin function register fields
    localparam int PF_STATUS_LSB = 0;
    localparam int PF_DIR_LSB = 8;
    localparam int PF_ONESHOT_LSB = 16;
    localparam int PF_INVERT_LSB = 24;

    // Output bit control fields
    localparam int OB_INDEX_LSB = 0;
    localparam int OB_VALUE_BIT = 3;

    // Feed and pulse modes
    localparam logic [1:0] FEED_PRESET = 2'h0;
    localparam logic [1:0] FEED_CONST = 2'h1;
    localparam logic [1:0] FEED_HIGH = 2'h2;
    localparam logic [1:0] PULSE_COMMON = 2'h0;
    localparam logic [1:0] PULSE_TWO = 2'h1;
    localparam logic [1:0] PULSE_QUAD = 2'h2;

    // Reset values
    localparam logic [6:0] RST_INPUT_LEVEL = 7'h00;
    localparam logic [1:0] RST_FEED = FEED_PRESET;
    localparam logic [1:0] RST_PULSE = PULSE_TWO;
    localparam logic [15:0] RST_ERC_WIDTH = 16'h0001;
    localparam logic [31:0] RST_PIN_FUNC = 32'h0000_0000;
    localparam logic [7:0] RST_OUT_PORT = 8'h00;

    // One-shot timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int ONESHOT_NS = 26_000_000;
    localparam int ONESHOT_CYC = ONESHOT_NS / CLK_PERIOD_NS;
    localparam int ONESHOT_W = 20;

endpackage

// ==== aisl_sync.sv ====
`timescale 1ns/1ps
module aisl_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } aisl_sync_t;

    aisl_sync_t st_q;
    aisl_sync_t st_d;

    if (WIDTH < 1)
    begin : g_chk
        $error("aisl_sync WIDTH must be at least 1");
    end

    always_comb
    begin
        st_d = st_q;
        st_d.meta = async_in;
        st_d.stable = st_q.meta;
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign sync_out = st_q.stable;

endmodule

// ==== aisl_axis_io.sv ====
// Decided for this implementation: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
module aisl_axis_io
    import aisl_pkg::*;
#(
    parameter int ONESHOT_CYCLES = ONESHOT_CYC
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic manual_drive_plus_switch,
    input wire logic manual_drive_minus_switch,
    input wire logic positioning_start_input,
    input wire logic in_position_input,
    input wire logic counter_reset_input,
    input wire logic counter_capture_input,
    input wire logic origin_sensor_input,
    input wire logic feeding,
    input wire logic accelerating,
    input wire logic decelerating,
    input wire logic constant_speed,
    input wire logic [4:0] comparator_hit,
    input wire logic output_pulse_strobe,
    input wire logic servo_clear_request,
    input wire logic [7:0] shared_general_pins_in,
    output logic [7:0] shared_general_pins_out,
    output logic [7:0] shared_general_pins_oe,
    output logic servo_deviation_clear_output,
    output logic axis_running_output_n,
    output logic soft_limit_plus,
    output logic soft_limit_minus,
    output logic manual_start_plus,
    output logic manual_start_minus,
    output logic [1:0] manual_feed_mode,
    output logic positioning_start,
    output logic [3:0] counter_clear,
    output logic [3:0] counter_capture,
    output logic origin_event,
    output logic [1:0] pulse_output_mode
);

    typedef struct packed {
        logic wr_pend;
        logic [5:0] wr_idx;
        logic rd_pend;
        logic [5:0] rd_idx;
        logic hready;
        logic [31:0] hrdata;
        logic [6:0] in_level;
        logic [3:0] clear_sel;
        logic [3:0] capture_sel;
        logic [1:0] feed_mode;
        logic [1:0] pulse_mode;
        logic [15:0] erc_width;
        logic erc_act_high;
        logic erc_level_mode;
        logic erc_level_on;
        logic [15:0] erc_count;
        logic erc_pin;
        logic [31:0] pin_func;
        logic [7:0] out_port;
        logic [1:0][ONESHOT_W-1:0] shot_count;
        logic [6:0] act_prev;
        logic org_sample;
        logic [7:0] pin_out;
        logic [7:0] pin_oe;
        logic running_n;
        logic sl_plus;
        logic sl_minus;
        logic start_plus;
        logic start_minus;
        logic pos_start;
        logic [3:0] cnt_clear;
        logic [3:0] cnt_capture;
        logic org_event;
    } aisl_state_t;

    aisl_state_t st_q;
    aisl_state_t st_d;

    if (ONESHOT_CYCLES < 1 || ONESHOT_CYCLES >= (1 << ONESHOT_W))
    begin : g_chk
        $error("ONESHOT_CYCLES out of range for the one-shot counter");
    end

    logic [NUM_IN+NUM_PINS-1:0] raw_in;
    logic [NUM_IN+NUM_PINS-1:0] sync_in;
    logic [6:0] in_sync;
    logic [7:0] pin_sync;
    logic [6:0] act;
    logic [6:0] act_rise;

    assign raw_in = {shared_general_pins_in, origin_sensor_input, counter_capture_input,
        counter_reset_input, in_position_input, positioning_start_input,
        manual_drive_minus_switch, manual_drive_plus_switch};

    // Synchronisers carry inverted levels so their cleared state reads as idle-high pins
    aisl_sync #(.WIDTH(NUM_IN + NUM_PINS)) u_sync (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .async_in(~raw_in),
        .sync_out(sync_in)
    );

    assign in_sync = ~sync_in[NUM_IN-1:0];
    assign pin_sync = ~sync_in[NUM_IN+NUM_PINS-1:NUM_IN];
    // Level bit 0 means active low, the reset state
    assign act = in_sync ^ ~st_q.in_level;
    assign act_rise = act & ~st_q.act_prev;

    function automatic logic drive_level(input logic active, input logic act_high);
        drive_level = act_high ? active : ~active;
    endfunction

    logic [7:0] status_val;
    logic [2:0] ob_index;
    logic ob_is_shot;

    always_comb
    begin
        // Status function values, before per-pin inversion
        status_val[0] = ~accelerating;
        status_val[1] = ~decelerating;
        status_val[2] = constant_speed;
        status_val[7:3] = comparator_hit;
    end

    assign ob_index = hwdata[OB_INDEX_LSB +: 3];
    assign ob_is_shot = (ob_index < 3'h2) && st_q.pin_func[PF_ONESHOT_LSB + int'(ob_index[0])];

    always_comb
    begin
        logic erc_active;
        logic [7:0] gen_val;
        logic [7:0] gen_oe;
        erc_active = 1'b0;
        gen_val = '0;
        gen_oe = '0;
        st_d = st_q;

        // Bus read data phase, else address phase
        st_d.wr_pend = 1'b0;
        if (st_q.rd_pend)
        begin
            st_d.rd_pend = 1'b0;
            st_d.hready = 1'b1;
            st_d.hrdata = '0;
            case ({st_q.rd_idx, 2'b00})
                OFS_INPUT_LEVEL: st_d.hrdata[6:0] = st_q.in_level;
                OFS_COUNTER_SEL: st_d.hrdata[11:0] = {st_q.pulse_mode, st_q.feed_mode,
                    st_q.capture_sel, st_q.clear_sel};
                OFS_ERC_CFG: st_d.hrdata[18:0] = {st_q.erc_level_on, st_q.erc_level_mode,
                    st_q.erc_act_high, st_q.erc_width};
                OFS_PIN_FUNC: st_d.hrdata = st_q.pin_func;
                OFS_OUT_PORT: st_d.hrdata[7:0] = st_q.out_port;
                OFS_EXT_STATUS: st_d.hrdata[15:0] = {pin_sync, st_q.erc_pin, act};
                default: st_d.hrdata = '0;
            endcase
        end
        else if (hsel && hready && htrans[1])
        begin
            st_d.wr_pend = hwrite;
            st_d.wr_idx = haddr[7:2];
            st_d.rd_idx = haddr[7:2];
            st_d.rd_pend = ~hwrite;
            st_d.hready = hwrite;
        end

        // Bus data phase of a write
        if (st_q.wr_pend)
        begin
            case ({st_q.wr_idx, 2'b00})
                OFS_INPUT_LEVEL: st_d.in_level = hwdata[6:0];
                OFS_COUNTER_SEL:
                begin
                    st_d.clear_sel = hwdata[SEL_CLEAR_LSB +: 4];
                    st_d.capture_sel = hwdata[SEL_CAPTURE_LSB +: 4];
                    st_d.feed_mode = hwdata[SEL_FEED_LSB +: 2];
                    st_d.pulse_mode = hwdata[SEL_PULSE_LSB +: 2];
                end
                OFS_ERC_CFG:
                begin
                    st_d.erc_width = hwdata[ERC_WIDTH_LSB +: 16];
                    st_d.erc_act_high = hwdata[ERC_ACT_HIGH_BIT];
                    st_d.erc_level_mode = hwdata[ERC_LEVEL_MODE_BIT];
                    st_d.erc_level_on = hwdata[ERC_LEVEL_ON_BIT];
                end
                OFS_PIN_FUNC: st_d.pin_func = hwdata;
                OFS_OUT_PORT: st_d.out_port = hwdata[7:0];
                OFS_OUT_BIT:
                begin
                    if (ob_is_shot)
                        st_d.shot_count[ob_index[0]] = ONESHOT_W'(ONESHOT_CYCLES);
                    else
                        st_d.out_port[ob_index] = hwdata[OB_VALUE_BIT];
                end
                default: st_d.out_port = st_q.out_port;
            endcase
        end

        // Input events
        st_d.act_prev = act;
        st_d.start_plus = act_rise[IN_DR_PLUS];
        st_d.start_minus = act_rise[IN_DR_MINUS];
        st_d.pos_start = act_rise[IN_POS_START];
        st_d.cnt_clear = act_rise[IN_CNT_RESET] ? st_q.clear_sel : 4'h0;
        st_d.cnt_capture = act_rise[IN_CNT_CAPTURE] ? st_q.capture_sel : 4'h0;

        // Origin acts on a change between pulse-synchronous samples
        st_d.org_event = 1'b0;
        if (output_pulse_strobe)
        begin
            st_d.org_sample = act[IN_ORIGIN];
            st_d.org_event = act[IN_ORIGIN] != st_q.org_sample;
        end

        // Servo deviation clear
        if (servo_clear_request && !st_q.erc_level_mode)
            st_d.erc_count = st_q.erc_width;
        else if (st_q.erc_count != 16'h0000)
            st_d.erc_count = st_q.erc_count - 16'h0001;
        erc_active = st_q.erc_level_mode ? st_q.erc_level_on : (st_d.erc_count != 16'h0000);
        st_d.erc_pin = drive_level(erc_active, st_q.erc_act_high);

        // One-shot counters
        for (int i = 0; i < 2; i++)
        begin
            if (st_d.shot_count[i] == st_q.shot_count[i] && st_q.shot_count[i] != '0)
                st_d.shot_count[i] = st_q.shot_count[i] - ONESHOT_W'(1);
        end

        // Shared pins
        for (int i = 0; i < NUM_PINS; i++)
        begin
            gen_val[i] = st_q.out_port[i];
            gen_oe[i] = st_q.pin_func[PF_DIR_LSB + i];
            if (i < 2 && st_q.pin_func[PF_ONESHOT_LSB + i])
            begin
                gen_val[i] = st_q.shot_count[i] != '0;
                gen_oe[i] = 1'b1;
            end
            if (st_q.pin_func[PF_STATUS_LSB + i])
            begin
                st_d.pin_out[i] = status_val[i] ^ st_q.pin_func[PF_INVERT_LSB + i];
                st_d.pin_oe[i] = 1'b1;
            end
            else
            begin
                st_d.pin_out[i] = gen_val[i] ^ st_q.pin_func[PF_INVERT_LSB + i];
                st_d.pin_oe[i] = gen_oe[i];
            end
        end

        st_d.running_n = ~feeding;
        st_d.sl_plus = comparator_hit[0];
        st_d.sl_minus = comparator_hit[1];
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            st_q <= '0;
            st_q.hready <= 1'b1;
            st_q.in_level <= RST_INPUT_LEVEL;
            st_q.feed_mode <= RST_FEED;
            st_q.pulse_mode <= RST_PULSE;
            st_q.erc_width <= RST_ERC_WIDTH;
            st_q.erc_pin <= 1'b1;
            st_q.pin_func <= RST_PIN_FUNC;
            st_q.out_port <= RST_OUT_PORT;
            st_q.act_prev <= 7'h00;
            st_q.running_n <= 1'b1;
        end
        else
            st_q <= st_d;
    end

    assign hrdata = st_q.hrdata;
    assign hreadyout = st_q.hready;
    assign hresp = 1'b0;
    assign shared_general_pins_out = st_q.pin_out;
    assign shared_general_pins_oe = st_q.pin_oe;
    assign servo_deviation_clear_output = st_q.erc_pin;
    assign axis_running_output_n = st_q.running_n;
    assign soft_limit_plus = st_q.sl_plus;
    assign soft_limit_minus = st_q.sl_minus;
    assign manual_start_plus = st_q.start_plus;
    assign manual_start_minus = st_q.start_minus;
    assign manual_feed_mode = st_q.feed_mode;
    assign positioning_start = st_q.pos_start;
    assign counter_clear = st_q.cnt_clear;
    assign counter_capture = st_q.cnt_capture;
    assign origin_event = st_q.org_event;
    assign pulse_output_mode = st_q.pulse_mode;

    // Checks
    manual_start_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        $rose(act[IN_DR_PLUS]) |=> manual_start_plus ##1 !manual_start_plus)
        else $error("manual plus start not a single pulse");
    pos_start_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        positioning_start |-> $past(act_rise[IN_POS_START]))
        else $error("positioning start without input edge");
    in_pos_read_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        st_q.rd_pend && st_q.rd_idx == OFS_EXT_STATUS[7:2]
        |=> hrdata[IN_IN_POS] == $past(act[IN_IN_POS]))
        else $error("in-position state not reported");
    counter_clear_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        act_rise[IN_CNT_RESET] |=> counter_clear == $past(st_q.clear_sel))
        else $error("counter clear does not follow selection");
    counter_capture_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        counter_capture != 4'h0 |-> $past(act_rise[IN_CNT_CAPTURE]))
        else $error("capture without input edge");
    erc_pulse_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        servo_clear_request && !st_q.erc_level_mode && st_q.erc_width == 16'h0003
        ##1 !servo_clear_request [*3]
        |-> servo_deviation_clear_output == st_q.erc_act_high
        ##1 servo_deviation_clear_output != st_q.erc_act_high)
        else $error("servo clear pulse width wrong");
    running_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        feeding [*2] |-> !axis_running_output_n)
        else $error("running output high while feeding");
    accel_pin_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        accelerating && st_q.pin_func[PF_STATUS_LSB] && !st_q.pin_func[PF_INVERT_LSB]
        ##1 st_q.pin_func[PF_STATUS_LSB] |-> !shared_general_pins_out[0])
        else $error("pin 0 not low while accelerating");
    cmp_pin_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        st_q.pin_func[PF_STATUS_LSB + 5] && !st_q.pin_func[PF_INVERT_LSB + 5] && comparator_hit[2]
        |=> shared_general_pins_out[5] && shared_general_pins_oe[5])
        else $error("comparator 3 pin not asserted");
    oneshot_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        $fell(st_q.shot_count[0] != '0) |-> $past(st_q.shot_count[0]) == ONESHOT_W'(1))
        else $error("one-shot ended early");
    origin_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        origin_event |-> $past(output_pulse_strobe))
        else $error("origin event not tied to an output pulse");

endmodule

// ==== aisl_partner.sv ====
`timescale 1ns/1ps
module aisl_partner (
    input wire logic [6:0] press,
    input wire logic [7:0] pins_out,
    input wire logic [7:0] pins_oe,
    output logic [6:0] pin_n,
    output logic [7:0] pins_wire
);
    // Switches, sensors and the servo driver pull their line low while active
    assign pin_n = ~press;
    // A pin nobody drives is held high by its pull-up
    assign pins_wire = (pins_oe & pins_out) | ~pins_oe;
endmodule

// ==== axis_io_signal_logic_bench.sv ====
`timescale 1ns/1ps
module axis_io_signal_logic_bench;
    import aisl_pkg::*;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic feeding = 1'b0;
    logic accelerating = 1'b0;
    logic decelerating = 1'b0;
    logic constant_speed = 1'b0;
    logic [4:0] comparator_hit = 5'h00;
    logic output_pulse_strobe = 1'b0;
    logic servo_clear_request = 1'b0;
    logic [6:0] press = 7'h00;
    logic [6:0] pin_n;
    logic [7:0] pins_out;
    logic [7:0] pins_oe;
    logic [7:0] pins_wire;
    logic servo_clr;
    logic running_n;
    logic sl_plus;
    logic sl_minus;
    logic st_plus;
    logic st_minus;
    logic [1:0] feed_mode;
    logic pos_start;
    logic [3:0] cnt_clear;
    logic [3:0] cnt_capture;
    logic origin_event;
    logic [1:0] pulse_mode;
    logic [3:0] clr_seen = 4'h0;
    logic [3:0] cap_seen = 4'h0;
    logic [31:0] r;
    int fail_count = 0;
    int checked = 0;
    int n;
    wire [5:0] evs = {origin_event, |cnt_capture, |cnt_clear, pos_start, st_minus, st_plus};

    always #25 clk_sys = ~clk_sys;

    always @(posedge clk_sys)
    begin
        if (|cnt_clear)
            clr_seen <= cnt_clear;
        if (|cnt_capture)
            cap_seen <= cnt_capture;
    end

    aisl_partner i_aisl_partner (.press(press), .pins_out(pins_out), .pins_oe(pins_oe), .pin_n(pin_n),
        .pins_wire(pins_wire));

    aisl_axis_io #(.ONESHOT_CYCLES(20)) i_aisl_axis_io (.clk_sys(clk_sys), .resetn(resetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .manual_drive_plus_switch(pin_n[0]),
        .manual_drive_minus_switch(pin_n[1]), .positioning_start_input(pin_n[2]), .in_position_input(pin_n[3]),
        .counter_reset_input(pin_n[4]), .counter_capture_input(pin_n[5]), .origin_sensor_input(pin_n[6]),
        .feeding(feeding), .accelerating(accelerating), .decelerating(decelerating),
        .constant_speed(constant_speed), .comparator_hit(comparator_hit), .output_pulse_strobe(output_pulse_strobe),
        .servo_clear_request(servo_clear_request), .shared_general_pins_in(pins_wire),
        .shared_general_pins_out(pins_out), .shared_general_pins_oe(pins_oe), .servo_deviation_clear_output(servo_clr),
        .axis_running_output_n(running_n), .soft_limit_plus(sl_plus), .soft_limit_minus(sl_minus),
        .manual_start_plus(st_plus), .manual_start_minus(st_minus), .manual_feed_mode(feed_mode),
        .positioning_start(pos_start), .counter_clear(cnt_clear), .counter_capture(cnt_capture),
        .origin_event(origin_event), .pulse_output_mode(pulse_mode));

    task results();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e)
        begin
            fail_count++;
            $display("FAIL t=%0t seen %h expected %h", $time, s, e);
        end
    endtask

    task cyc(input int k);
        repeat (k) @(posedge clk_sys);
    endtask

    // Waits for hready under a bound; a hang ends the run
    task wait_ready();
        int k;
        k = 0;
        do
        begin
            @(posedge clk_sys);
            k++;
        end
        while (hreadyout !== 1'b1 && k < 40);
        if (k >= 40)
        begin
            fail_count++;
            results();
        end
    endtask

    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        r = hrdata;
    endtask

    // Counts cycles in which one event output is high
    task cnt(input int s, input int k);
        n = 0;
        repeat (k)
        begin
            @(posedge clk_sys);
            if (evs[s] === 1'b1)
                n++;
        end
    endtask

    task ev(input int i, input int s);
        press[i] <= 1'b1;
        cnt(s, 8);
        press[i] <= 1'b0;
        cyc(6);
    endtask

    task t_reset();
        chk({hreadyout, hresp, running_n, servo_clr, pulse_mode, pins_oe}, {4'hB, 2'h1, 8'h00});
        bus(1'b0, OFS_COUNTER_SEL, 32'h0);
        chk(r, 32'h0000_0400);
        bus(1'b0, OFS_ERC_CFG, 32'h0);
        chk(r, 32'h0000_0001);
        bus(1'b0, OFS_PIN_FUNC, 32'h0);
        chk(r, 32'h0000_0000);
        bus(1'b1, 8'h20, 32'hFFFF_FFFF);
        bus(1'b0, 8'h20, 32'h0);
        chk(r, 32'h0000_0000);
    endtask

    task t_inputs();
        for (int m = 0; m < 3; m++)
        begin
            bus(1'b1, OFS_COUNTER_SEL, 32'h0000_04A5 | (m << 8));
            cyc(1);
            chk(feed_mode, m);
        end
        bus(1'b1, OFS_COUNTER_SEL, 32'h0000_09A5);
        cyc(1);
        chk(pulse_mode, PULSE_QUAD);
        ev(0, 0);
        chk(n, 1);
        ev(1, 1);
        chk(n, 1);
        ev(2, 2);
        chk(n, 1);
        ev(4, 3);
        chk({n[3:0], clr_seen}, 8'h15);
        ev(5, 4);
        chk({n[3:0], cap_seen}, 8'h1A);
        press[3] <= 1'b1;
        cyc(4);
        bus(1'b0, OFS_EXT_STATUS, 32'h0);
        chk(r[3], 1'b1);
        bus(1'b1, OFS_INPUT_LEVEL, 32'h0000_0008);
        cyc(3);
        bus(1'b0, OFS_EXT_STATUS, 32'h0);
        chk(r[3], 1'b0);
        bus(1'b1, OFS_INPUT_LEVEL, 32'h0000_0000);
        press[3] <= 1'b0;
    endtask

    task t_origin();
        press[6] <= 1'b1;
        cnt(5, 8);
        chk(n, 0);
        // Sensor stays on across several output pulses
        n = 0;
        repeat (12)
        begin
            @(posedge clk_sys);
            if (origin_event === 1'b1)
                n++;
            output_pulse_strobe <= ~output_pulse_strobe;
        end
        cyc(3);
        chk(n, 1);
    endtask

    task t_status();
        feeding <= 1'b1;
        cyc(3);
        chk(running_n, 1'b0);
        feeding <= 1'b0;
        cyc(3);
        chk(running_n, 1'b1);
        bus(1'b1, OFS_PIN_FUNC, 32'h0000_00FF);
        accelerating <= 1'b1;
        constant_speed <= 1'b1;
        comparator_hit <= 5'h1F;
        cyc(3);
        chk({pins_oe, pins_out}, 16'hFFFE);
        accelerating <= 1'b0;
        decelerating <= 1'b1;
        constant_speed <= 1'b0;
        comparator_hit <= 5'h02;
        cyc(3);
        chk({pins_out, sl_plus, sl_minus}, 10'h045);
        bus(1'b1, OFS_PIN_FUNC, 32'h0400_00FF);
        constant_speed <= 1'b1;
        cyc(3);
        chk(pins_out[2], 1'b0);
        decelerating <= 1'b0;
        constant_speed <= 1'b0;
        comparator_hit <= 5'h00;
    endtask

    task t_general();
        bus(1'b1, OFS_PIN_FUNC, 32'h0000_FF00);
        bus(1'b1, OFS_OUT_PORT, 32'h0000_005A);
        cyc(2);
        chk({pins_oe, pins_out}, 16'hFF5A);
        bus(1'b1, OFS_OUT_BIT, 32'h0000_0008);
        bus(1'b1, OFS_OUT_BIT, 32'h0000_0006);
        cyc(4);
        bus(1'b0, OFS_EXT_STATUS, 32'h0);
        chk({pins_out, r[15:8]}, 16'h1B1B);
        bus(1'b1, OFS_PIN_FUNC, 32'h0000_0000);
        cyc(4);
        bus(1'b0, OFS_EXT_STATUS, 32'h0);
        chk({pins_oe, r[15:8]}, 16'h00FF);
        bus(1'b1, OFS_OUT_PORT, 32'h0000_0000);
        bus(1'b1, OFS_PIN_FUNC, 32'h0001_FF00);
        bus(1'b1, OFS_OUT_BIT, 32'h0000_0000);
        n = 0;
        repeat (40)
        begin
            @(posedge clk_sys);
            if (pins_out[0] === 1'b1)
                n++;
        end
        chk(n, 20);
    endtask

    task t_servo();
        bus(1'b1, OFS_ERC_CFG, 32'h0001_0003);
        cyc(2);
        chk(servo_clr, 1'b0);
        servo_clear_request <= 1'b1;
        @(posedge clk_sys);
        servo_clear_request <= 1'b0;
        n = 0;
        repeat (10)
        begin
            @(posedge clk_sys);
            if (servo_clr === 1'b1)
                n++;
        end
        chk(n, 3);
        bus(1'b1, OFS_ERC_CFG, 32'h0006_0000);
        cyc(3);
        bus(1'b0, OFS_EXT_STATUS, 32'h0);
        chk({servo_clr, r[7]}, 2'h0);
        bus(1'b1, OFS_ERC_CFG, 32'h0002_0000);
        cyc(2);
        chk(servo_clr, 1'b1);
    endtask

    initial
    begin
        cyc(4);
        resetn <= 1'b1;
        @(posedge clk_sys);
        t_reset();
        t_inputs();
        t_origin();
        t_status();
        t_general();
        t_servo();
        results();
    end
endmodule
